// file: src/adcsw_pkg.sv
/*
  Package for the scan sweep sequencer: APB register map, field layout,
  RAM transfer addresses, timing counts and shared types.
  Assumes a single 125 MHz clock domain and a 32-bit APB master.
*/
package adcsw_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_XFEN = 12'h004;
  localparam logic [11:0] OFF_LIMIT = 12'h008;
  localparam logic [11:0] OFF_RESULT = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_GATE_BIT = 1;
  localparam int XFEN_CONVEND_BIT = 5;
  localparam int LIM_LOWER_LSB = 0;
  localparam int LIM_UPPER_LSB = 8;
  localparam int IRQ_SWEEP_BIT = 0;
  localparam int IRQ_CONV_BIT = 1;

  localparam logic [7:0] UPPER_LIMIT_RESET = 8'hff;
  localparam logic [7:0] LOWER_LIMIT_RESET = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  localparam logic [19:0] RESULT_ADDR = 20'hfff1e;
  localparam logic [19:0] RAM_BASE_ADDR = 20'hff500;
  localparam logic [19:0] RAM_STEP = 20'h00002;
  localparam logic [2:0] XFER_PRESET = 3'h4;
  localparam logic [1:0] LAST_CHANNEL = 2'h3;
  localparam int RESULT_SHIFT = 6;

  localparam logic [2:0] CONV_DIV = 3'h7;
  localparam logic [4:0] CONV_CLOCKS = 5'h0e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CONV = 5'b00010,
    ST_XFER = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_NEXT = 5'b10000
  } adcsw_state_e;

  typedef struct packed {
    logic req;
    logic [19:0] addr;
    logic [15:0] data;
  } adcsw_ram_s;
endpackage

// file: src/adcsw_sweep.sv
/*
  Scan sweep sequencer: one-shot scan of four inputs, transfer of each result
  to four RAM slots in repeat mode, window compare, interrupt on sweep end.
  Assumes a synchronous front end that returns a 10-bit sample on a done
  pulse, and a RAM port that acknowledges each 16-bit write.
*/
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// Behaviour
// - Scan inputs zero to three in ascending order, one after another.
// - Each finished conversion updates the result register and, inside the window, pulses conversion end.
// - Each conversion end triggers a RAM write of the result before next result.
// - Transfer count preset four; fourth transfer raises the sweep interrupt request.
// - Destinations step by two bytes from FF500H to FF507H; source fixed.
// - Each transfer is one 16-bit access sourced from result register FFF1EH.
// - Transfer-end condition clears the conversion-end transfer trigger enable.
// - Conversion end only when lower limit <= result <= upper limit.
// - Conversion clock is the peripheral clock divided by eight.
// - Result held left-aligned in sixteen bits; consumers shift right by six.
// - Converter register writes are ignored while the clock gate is off.
module adcsw_sweep
  import adcsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] channel,
  output logic sampleStart,
  input wire logic sampleDone,
  input wire logic [9:0] sampleData,
  output adcsw_ram_s ram,
  input wire logic ramAck,
  output logic convClk,
  output logic irq
);
  adcsw_state_e state;
  adcsw_state_e next_state;
  logic run;
  logic clockGate;
  logic [7:0] xferEnable;
  logic [7:0] upperLimit;
  logic [7:0] lowerLimit;
  logic [15:0] result;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [2:0] xferCount;
  logic [2:0] divCount;
  logic [4:0] convCount;
  logic [9:0] sample;

  // APB decode
  wire apbAccess = psel && penable;
  wire apbWrite = apbAccess && pwrite;
  wire hitCtrl = paddr == OFF_CTRL;
  wire hitXfen = paddr == OFF_XFEN;
  wire hitLimit = paddr == OFF_LIMIT;
  wire hitResult = paddr == OFF_RESULT;
  wire hitStat = paddr == OFF_IRQ_STAT;
  wire hitMask = paddr == OFF_IRQ_MASK;
  wire hitStatus = paddr == OFF_STATUS;
  wire mapped = hitCtrl | hitXfen | hitLimit | hitResult | hitStat | hitMask | hitStatus;

  // Converter registers only; the gate bit itself always stays writable
  wire convWriteOk = clockGate;
  wire wrCtrl = apbWrite && hitCtrl;
  wire wrXfen = apbWrite && hitXfen && convWriteOk;
  wire wrLimit = apbWrite && hitLimit && convWriteOk;
  wire wrStat = apbWrite && hitStat;
  wire wrMask = apbWrite && hitMask;

  // Sequencer events
  wire divTick = divCount == CONV_DIV;
  // Window check uses the upper eight bits of the left-aligned result
  wire [7:0] sampleTop = sample[9:2];
  wire inWindow = (lowerLimit <= sampleTop) && (sampleTop <= upperLimit);
  wire convEnd = (state == ST_WAIT) && inWindow;
  wire xferTrig = convEnd && xferEnable[XFEN_CONVEND_BIT];
  wire xferDone = (state == ST_XFER) && ramAck;
  wire lastXfer = xferDone && (xferCount == 3'h1);
  wire sweepEnd = (state == ST_NEXT) && (channel == LAST_CHANNEL);
  wire [1:0] irqEvents = {convEnd, lastXfer};

  // Next values of the counters, kept out of the clocked blocks
  wire [2:0] next_divCount = divCount + 3'h1;
  wire [4:0] next_convCount = convCount + 5'h1;
  wire [1:0] next_channel = channel + 2'h1;
  wire [2:0] next_xferCount = xferCount - 3'h1;
  wire [19:0] next_ramAddr = ram.addr + RAM_STEP;

  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;
  assign irq = |(irqStatus & irqMask);
  assign sampleStart = (state == ST_CONV) && (convCount == 5'h0) && divTick;

  // One channel completes, transfer included, before the next one starts
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (run) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sampleDone) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state = xferTrig ? ST_XFER : ST_NEXT;
      end
      ST_XFER: begin
        if (ramAck) begin
          next_state = ST_NEXT;
        end
      end
      ST_NEXT: begin
        next_state = (channel == LAST_CHANNEL) ? ST_IDLE : ST_CONV;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Free-running divider keeps every start on the conversion clock grid
  always_ff @(posedge clk) begin
    if (rst) begin
      divCount <= 3'h0;
    end else begin
      divCount <= next_divCount;
    end
  end

  // Registered so the divided clock carries no decode glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      convClk <= 1'b0;
    end else begin
      convClk <= divCount[2];
    end
  end

  // Conversion paced in conversion-clock periods, one channel at a time
  always_ff @(posedge clk) begin
    if (rst || state != ST_CONV) begin
      convCount <= 5'h0;
    end else if (divTick && convCount != CONV_CLOCKS) begin
      convCount <= next_convCount;
    end
  end

  // Back to input zero in idle so every sweep starts there
  always_ff @(posedge clk) begin
    if (rst) begin
      channel <= 2'h0;
    end else if (state == ST_IDLE) begin
      channel <= 2'h0;
    end else if (state == ST_NEXT && channel != LAST_CHANNEL) begin
      channel <= next_channel;
    end
  end

  // Raw sample kept for the window compare
  always_ff @(posedge clk) begin
    if (rst) begin
      sample <= 10'h0;
    end else if (state == ST_CONV && sampleDone) begin
      sample <= sampleData;
    end
  end

  // Left-aligned; a consumer shifts right by six for the raw value
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= 16'h0;
    end else if (state == ST_CONV && sampleDone) begin
      result <= {sampleData, 6'h0};
    end
  end

  // Run stays busy until the scan ends; a write of zero clears it, but the scan runs on to the end
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
    end else if (sweepEnd) begin
      run <= 1'b0;
    end else if (wrCtrl && convWriteOk) begin
      run <= pwdata[CTRL_RUN_BIT];
    end
  end

  // Never gated itself, or the block could not be woken again
  always_ff @(posedge clk) begin
    if (rst) begin
      clockGate <= 1'b0;
    end else if (wrCtrl) begin
      clockGate <= pwdata[CTRL_GATE_BIT];
    end
  end

  // Hardware clear wins so a late re-enable cannot arm a finished sweep
  always_ff @(posedge clk) begin
    if (rst) begin
      xferEnable <= 8'h0;
    end else if (lastXfer) begin
      xferEnable[XFEN_CONVEND_BIT] <= 1'b0;
    end else if (wrXfen) begin
      xferEnable <= pwdata[7:0];
    end
  end

  // Limits reset to the full window so every result counts
  always_ff @(posedge clk) begin
    if (rst) begin
      upperLimit <= UPPER_LIMIT_RESET;
    end else if (wrLimit) begin
      upperLimit <= pwdata[LIM_UPPER_LSB +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lowerLimit <= LOWER_LIMIT_RESET;
    end else if (wrLimit) begin
      lowerLimit <= pwdata[LIM_LOWER_LSB +: 8];
    end
  end

  // Reload on the last transfer keeps the repeat area ready for the next sweep
  always_ff @(posedge clk) begin
    if (rst) begin
      xferCount <= XFER_PRESET;
    end else if (lastXfer) begin
      xferCount <= XFER_PRESET;
    end else if (xferDone) begin
      xferCount <= next_xferCount;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ram.addr <= RAM_BASE_ADDR;
    end else if (lastXfer) begin
      ram.addr <= RAM_BASE_ADDR;
    end else if (xferDone) begin
      ram.addr <= next_ramAddr;
    end
  end

  // Source is always the result register, one 16-bit beat per transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      ram.req <= 1'b0;
      ram.data <= 16'h0;
    end else if (xferTrig) begin
      ram.req <= 1'b1;
      ram.data <= result;
    end else if (xferDone) begin
      ram.req <= 1'b0;
    end
  end

  // Set wins over a write-one clear in the same cycle
  wire [1:0] irqClear = wrStat ? pwdata[1:0] : 2'h0;
  wire [1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= 2'h0;
    end else begin
      irqStatus <= next_irqStatus;
    end
  end

  // Mask only gates the output; status keeps collecting events
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (wrMask) begin
      irqMask <= pwdata[1:0];
    end
  end

  // Read-back words
  wire [31:0] rdCtrl = {30'h0, clockGate, run};
  wire [31:0] rdLimit = {16'h0, upperLimit, lowerLimit};
  wire [31:0] rdStatus = {24'h0, 3'h0, xferCount, channel};
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0;
    unique case (paddr)
      OFF_CTRL: begin
        rdMux = rdCtrl;
      end
      OFF_XFEN: begin
        rdMux = {24'h0, xferEnable};
      end
      OFF_LIMIT: begin
        rdMux = rdLimit;
      end
      OFF_RESULT: begin
        rdMux = {16'h0, result};
      end
      OFF_IRQ_STAT: begin
        rdMux = {30'h0, irqStatus};
      end
      OFF_IRQ_MASK: begin
        rdMux = {30'h0, irqMask};
      end
      OFF_STATUS: begin
        rdMux = rdStatus;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // Captured in the setup cycle so read data stands through the access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end
endmodule

// file: testbench/adcsw_sweep_props.sv
/*
  Checker for the scan sweep sequencer, bound to its top module.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module adcsw_sweep_props
  import adcsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] channel,
  input wire logic sampleStart,
  input wire logic sampleDone,
  input wire adcsw_ram_s ram,
  input wire logic ramAck,
  input wire logic convClk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_chan_step: assert property (
    $changed(channel) |-> channel == $past(channel) + 2'h1)
    else $error("Channel did not step by one");
  a_start_pulse: assert property (
    sampleStart |=> !sampleStart)
    else $error("Start pulse too long");
  a_req_holds: assert property (
    ram.req && !ramAck |=> ram.req && $stable(ram.addr) && $stable(ram.data))
    else $error("RAM request dropped or changed before ack");
  a_xfer_first: assert property (
    sampleStart |-> !ram.req)
    else $error("Conversion started with transfer pending");
  a_req_cause: assert property (
    $rose(ram.req) |-> $past(sampleDone, 2) || $past(sampleDone, 3))
    else $error("Transfer without conversion end");
  a_dest_range: assert property (
    ram.req |-> ram.addr[19:3] == RAM_BASE_ADDR[19:3] && !ram.addr[0])
    else $error("Destination outside repeat area");
  a_left_align: assert property (
    ram.req |-> ram.data[5:0] == 6'h00)
    else $error("Result not left aligned");
  a_div_eight: assert property (
    $changed(convClk) |=> $stable(convClk)[*3] ##1 $changed(convClk))
    else $error("Conversion clock not divided by eight");
endmodule

bind adcsw_sweep adcsw_sweep_props i_props (
  .clk(clk),
  .rst(rst),
  .channel(channel),
  .sampleStart(sampleStart),
  .sampleDone(sampleDone),
  .ram(ram),
  .ramAck(ramAck),
  .convClk(convClk)
);

// file: testbench/adcsw_front.sv
/*
  Model of the analog front end and the RAM port.
  Assumes the sweep block's start/done and request/ack handshakes.
*/
`timescale 1ns/10ps
module adcsw_front
  import adcsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [9:0] base,
  input wire logic sampleStart,
  input wire logic [1:0] channel,
  input wire adcsw_ram_s ram,
  output logic sampleDone,
  output logic [9:0] sampleData,
  output logic ramAck,
  output logic [15:0] mem [4],
  output logic [3:0] acks
);
  int cnt;
  int dly;
  logic [1:0] ch;
  always @(posedge clk) begin
    sampleDone <= 1'b0;
    ramAck <= 1'b0;
    if (rst) begin
      cnt <= 0;
      dly <= 0;
      acks <= 4'h0;
      sampleData <= 10'h155;
    end else begin
      // Data is not held after the strobe, so a late capture shows up
      if (sampleDone) sampleData <= ~sampleData;
      if (sampleStart) begin
        cnt <= slow ? 40 : 3;
        ch <= channel;
      end else if (cnt == 1) begin
        sampleDone <= 1'b1;
        sampleData <= base + 10'(ch) * 10'h041;
        cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
      if (ram.req && !ramAck) begin
        if (dly >= (slow ? 4 : 0)) begin
          ramAck <= 1'b1;
          mem[ram.addr[2:1]] <= ram.data;
          acks <= acks + 4'h1;
          dly <= 0;
        end else dly <= dly + 1;
      end
    end
  end
endmodule

// file: testbench/adcsw_sweep_bench.sv
/*
  Bench for the scan sweep sequencer: APB tasks and two sweeps.
  Assumes the front end and RAM model beside the design.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module adcsw_sweep_bench
  import adcsw_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sampleStart, sampleDone, ramAck, convClk, irq;
  logic [1:0] channel;
  logic [9:0] sampleData, base = 10'h012;
  logic [15:0] mem [4];
  logic [3:0] acks;
  adcsw_ram_s ram;
  int mismatches = 0, totalChecks = 0;
  adcsw_sweep i_adcsw_sweep (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel(channel), .sampleStart(sampleStart), .sampleDone(sampleDone),
    .sampleData(sampleData), .ram(ram), .ramAck(ramAck), .convClk(convClk), .irq(irq));
  adcsw_front i_adcsw_front (.clk(clk), .rst(rst), .slow(slow), .base(base),
    .sampleStart(sampleStart), .channel(channel), .ram(ram), .sampleDone(sampleDone),
    .sampleData(sampleData), .ramAck(ramAck), .mem(mem), .acks(acks));
  initial forever #4 clk = ~clk;
  task complete_run;
    if (mismatches == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  function automatic logic [15:0] ex(input int c);
    ex = {base + 10'(c) * 10'h041, 6'h00};
  endfunction
  initial begin
    int n;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFF_LIMIT, 32'h0000ff00, "limit");
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_XFEN, 32'h20);
    rdchk(OFF_CTRL, 32'h0, "ctrl gated");
    rdchk(OFF_XFEN, 32'h0, "xfen gated");
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      base <= s[0] ? 10'h3c7 : 10'h012;
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_XFEN, 32'h20);
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h3);
      n = 0;
      do begin
        apb(1'b0, OFF_CTRL, 32'h0);
        n++;
      end while (rd[CTRL_RUN_BIT] !== 1'b0 && n < 400);
      if (rd[CTRL_RUN_BIT] !== 1'b0) begin
        mismatches++;
        complete_run();
      end
      `CHK("ctrl done", 32'h2, rd)
      `CHK("masked", 1'b0, irq)
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      @(negedge clk);
      `CHK("irq", 1'b1, irq)
      for (int c = 0; c < 4; c++) `CHK("slot", ex(c), mem[c])
      rdchk(OFF_RESULT, {16'h0, ex(3)}, "result");
      rdchk(OFF_XFEN, 32'h0, "xfen");
      rdchk(OFF_IRQ_STAT, 32'h3, "stat");
      apb(1'b1, OFF_IRQ_STAT, 32'h3);
      @(negedge clk);
      `CHK("cleared", 1'b0, irq)
    end
    `CHK("acks", 4'h8, acks)
    apb(1'b0, 12'h01c, 32'h0);
    `CHK("unmapped", 1'b1, err)
    complete_run();
  end
endmodule
